// ===== i2c_slave_event.sv
`timescale 1ns/1ps
// What this block does
// - as slave transmitter keep sending while acked, stop after a nack.
// - a receiver ends by leaving the ack bit high after its last byte.
// - an extension code after start always makes this slave take part.
// - after a data byte event hold clock low until software releases.
// - an address matching neither own address nor extension code is ignored.
// - a readable direction flag shows transmitting or receiving.
// - master flag is refreshed in the same cycle as every transfer event.
// - stop raises the stop event only while stop event enable is set.
// - transmit data leaves msb first, shifting on clock falling edges.
// - the data line is sampled into the shift register on rising edges.
// - a slave wait ends on a data write (all ones when receiving) or the release bit.
module i2c_slave_event
	import slave_evt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe,
	input wire logic serial_data_pin_i,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe,
	output logic serial_event_irq
);
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic scl_d_q;
	logic sda_d_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;
	logic wr_ctrl;
	logic wr_shift;
	logic wr_own;
	logic wr_stat;
	logic wr_mask;
	logic enable_q;
	logic stop_irq_enable;
	logic wait_irq_timing_select;
	logic ack_en_q;
	logic wait_release_bit;
	logic [6:0] own_slave_address_reg;
	logic [7:0] serial_shift_reg;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	phase_t phase_q;
	logic [3:0] bit_cnt_q;
	logic ack_slot_q;
	logic tx_bit_q;
	logic transmit_direction_flag;
	logic nack_q;
	logic ext_q;
	logic busy_q;
	logic stop_seen_q;
	logic wait_q;
	logic master_state_flag;
	logic active;
	logic own_hit;
	logic ext_hit;
	logic ack_fall;
	logic nine_fall;
	logic tx_nack_end;
	logic ev_byte;
	logic release_wait;
	logic [7:0] status_byte;

	// both pins come from the bus, so they cross into core_clk first
	pin_sync #(.W(2)) u_pin_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.d({serial_clock_pin_i, serial_data_pin_i}),
		.q(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// previous pin levels for edge and condition detection
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	// start: data falls with clock high; stop: data rises with clock high
	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign start_det = enable_q & scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign stop_det = enable_q & scl_s & scl_d_q & ~sda_d_q & sda_s;

	// bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// latch write address phase; the data phase commits on the next edge
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= hsel & htrans[1] & hready & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// write strobes per register; unmapped offsets are dropped
	assign wr_ctrl = wr_pend_q & (wr_addr_q == OFF_CTRL);
	assign wr_shift = wr_pend_q & (wr_addr_q == OFF_SHIFT);
	assign wr_own = wr_pend_q & (wr_addr_q == OFF_OWN_ADDR);
	assign wr_stat = wr_pend_q & (wr_addr_q == OFF_IRQ_STAT);
	assign wr_mask = wr_pend_q & (wr_addr_q == OFF_IRQ_MASK);
	assign wait_release_bit = wr_ctrl & hwdata[CTRL_WAIT_REL];

	// status snapshot, read as one byte
	assign status_byte = {wait_q, busy_q, stop_seen_q, ~nack_q, ext_q, phase_q != PH_IDLE,
		master_state_flag, transmit_direction_flag};

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (haddr[7:0])
			OFF_CTRL: rd_word[4:0] = {ack_en_q, 1'b0, wait_irq_timing_select,
				stop_irq_enable, enable_q};
			OFF_STATUS: rd_word[7:0] = status_byte;
			OFF_SHIFT: rd_word[7:0] = serial_shift_reg;
			OFF_OWN_ADDR: rd_word[7:0] = {own_slave_address_reg, 1'b0};
			OFF_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_q;
			OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_q;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// read data is captured at the address phase and stands in the data phase
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (hsel & htrans[1] & hready & ~hwrite) begin
			hrdata_q <= rd_word;
		end
	end

	// control and address registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			enable_q <= CTRL_RST[CTRL_ENABLE];
			stop_irq_enable <= CTRL_RST[CTRL_STOP_IRQ_EN];
			wait_irq_timing_select <= CTRL_RST[CTRL_WAIT_TIMING];
			ack_en_q <= CTRL_RST[CTRL_ACK_EN];
			own_slave_address_reg <= OWN_ADDR_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else begin
			if (wr_ctrl) begin
				enable_q <= hwdata[CTRL_ENABLE];
				stop_irq_enable <= hwdata[CTRL_STOP_IRQ_EN];
				wait_irq_timing_select <= hwdata[CTRL_WAIT_TIMING];
				ack_en_q <= hwdata[CTRL_ACK_EN];
			end
			if (wr_own) begin
				own_slave_address_reg <= hwdata[7:1];
			end
			if (wr_mask) begin
				irq_mask_q <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// address decode on the received first byte
	assign active = phase_q != PH_IDLE;
	assign own_hit = serial_shift_reg[7:1] == own_slave_address_reg;
	assign ext_hit = (serial_shift_reg[7:4] == EXT_PREFIX_LO) |
		(serial_shift_reg[7:3] == EXT_PREFIX_HI);
	assign ack_fall = active & scl_fall & (bit_cnt_q == BYTE_BITS);
	assign nine_fall = active & scl_fall & (bit_cnt_q == ACK_CLK);
	assign tx_nack_end = nine_fall & (phase_q == PH_DATA) & transmit_direction_flag & nack_q;

	// transfer event after clock eight or nine of data; address always nine
	assign ev_byte = (ack_fall & (phase_q == PH_DATA) & ~wait_irq_timing_select) |
		(nine_fall & ((phase_q == PH_ADDR) | wait_irq_timing_select));

	// byte framing and participation state
	always_ff @(posedge core_clk) begin
		if (!rstn || !enable_q) begin
			phase_q <= PH_IDLE;
			bit_cnt_q <= 4'd0;
			ack_slot_q <= 1'b0;
			tx_bit_q <= 1'b0;
			transmit_direction_flag <= 1'b0;
			nack_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (start_det) begin
			// a repeated start also lands here and re-arms address matching
			phase_q <= PH_ADDR;
			bit_cnt_q <= 4'd0;
			ack_slot_q <= 1'b0;
			tx_bit_q <= 1'b0;
			transmit_direction_flag <= 1'b0;
			nack_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (stop_det) begin
			phase_q <= PH_IDLE;
			bit_cnt_q <= 4'd0;
			ack_slot_q <= 1'b0;
			tx_bit_q <= 1'b0;
		end else if (active) begin
			if (scl_rise && bit_cnt_q != ACK_CLK) begin
				bit_cnt_q <= bit_cnt_q + 4'd1;
				if (bit_cnt_q == BYTE_BITS && transmit_direction_flag && phase_q == PH_DATA) begin
					nack_q <= sda_s; // high on the ack clock means no more data wanted
				end
			end
			if (ack_fall) begin
				tx_bit_q <= 1'b0;
				unique case (phase_q)
					PH_ADDR: begin
						if (own_hit || ext_hit) begin
							ack_slot_q <= 1'b1;
							ext_q <= ext_hit & ~own_hit;
							transmit_direction_flag <= serial_shift_reg[0] & own_hit;
						end else begin
							phase_q <= PH_IDLE;
						end
					end
					PH_DATA: begin
						ack_slot_q <= ~transmit_direction_flag;
					end
					PH_IDLE: begin
						ack_slot_q <= 1'b0;
					end
				endcase
			end
			if (nine_fall) begin
				bit_cnt_q <= 4'd0;
				ack_slot_q <= 1'b0;
				if (tx_nack_end) begin
					phase_q <= PH_IDLE;
					tx_bit_q <= 1'b0;
				end else begin
					phase_q <= PH_DATA;
					tx_bit_q <= transmit_direction_flag;
				end
			end
		end
	end

	// shift register: software load, receive on rise, transmit on fall
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			serial_shift_reg <= SHIFT_RST;
		end else if (wr_shift) begin
			serial_shift_reg <= hwdata[7:0];
		end else if (active && scl_rise && !tx_bit_q && bit_cnt_q < BYTE_BITS) begin
			serial_shift_reg <= {serial_shift_reg[6:0], sda_s};
		end else if (tx_bit_q && scl_fall && bit_cnt_q != 4'd0 && bit_cnt_q < BYTE_BITS) begin
			serial_shift_reg <= {serial_shift_reg[6:0], 1'b1};
		end
	end

	// wait release: any data write (all ones when receiving) or the release bit
	assign release_wait = wait_release_bit | (wr_shift & (hwdata[7:0] == DATA_ALL_ONES)) |
		(wr_shift & transmit_direction_flag);

	// clock hold; a new event wins over a release in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rstn || !enable_q || start_det || stop_det) begin
			wait_q <= 1'b0;
		end else if (ev_byte) begin
			wait_q <= 1'b1;
		end else if (release_wait) begin
			wait_q <= 1'b0;
		end
	end

	// bus progress flags
	always_ff @(posedge core_clk) begin
		if (!rstn || !enable_q) begin
			busy_q <= 1'b0;
			stop_seen_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
			stop_seen_q <= 1'b0;
		end else if (stop_det) begin
			busy_q <= 1'b0;
			stop_seen_q <= 1'b1;
		end
	end

	// slave-only engine: no arbitration is ever won, refreshed in the same cycle as each event
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			master_state_flag <= 1'b0;
		end else if (start_det || stop_det || ack_fall || nine_fall) begin
			master_state_flag <= 1'b0;
		end
	end

	// sticky events; the stop event only while enabled
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_XFER] = ev_byte;
		irq_set[IRQ_STOP] = stop_det & stop_irq_enable;
		irq_set[IRQ_NACK] = tx_nack_end;
	end

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_stat ? hwdata[IRQ_W-1:0] : '0)) | irq_set;
		end
	end

	assign serial_event_irq = |(irq_stat_q & irq_mask_q);

	// open-drain pins: only ever pull low
	assign serial_clock_pin_o = 1'b0;
	assign serial_data_pin_o = 1'b0;
	assign serial_clock_pin_oe = wait_q;
	// receive ack follows the ack enable, so clearing it ends reception
	assign serial_data_pin_oe = (ack_slot_q & ((phase_q == PH_ADDR) | ack_en_q)) |
		(tx_bit_q & ~serial_shift_reg[7]);

	// checks
	a_wait_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		(wait_q && !release_wait && !stop_det && !start_det && enable_q) |=>
		wait_q && serial_clock_pin_oe)
		else $error("clock wait dropped without release");
	a_wait_release: assert property (@(posedge core_clk) disable iff (!rstn)
		(wait_q && release_wait && !ev_byte) |=> !serial_clock_pin_oe)
		else $error("clock wait not released");
	a_stop_irq_gated: assert property (@(posedge core_clk) disable iff (!rstn)
		(stop_det && !stop_irq_enable && !irq_stat_q[IRQ_STOP]) |=> !irq_stat_q[IRQ_STOP])
		else $error("stop event raised while disabled");
	a_stop_irq_raised: assert property (@(posedge core_clk) disable iff (!rstn)
		(stop_det && stop_irq_enable) |=> irq_stat_q[IRQ_STOP])
		else $error("stop event missing");
	a_address_miss: assert property (@(posedge core_clk) disable iff (!rstn)
		(ack_fall && phase_q == PH_ADDR && !own_hit && !ext_hit && !start_det && !stop_det) |=>
		phase_q == PH_IDLE && !serial_data_pin_oe)
		else $error("unmatched address answered");
	a_ext_joins: assert property (@(posedge core_clk) disable iff (!rstn)
		(ack_fall && phase_q == PH_ADDR && ext_hit && enable_q && !start_det && !stop_det) |=>
		ack_slot_q ##0 serial_data_pin_oe)
		else $error("extension code not acknowledged");
	a_nack_ends: assert property (@(posedge core_clk) disable iff (!rstn)
		(tx_nack_end && !start_det && !stop_det) |=> phase_q == PH_IDLE && !tx_bit_q)
		else $error("transmission continued after nack");
	a_early_event: assert property (@(posedge core_clk) disable iff (!rstn)
		(ack_fall && phase_q == PH_DATA && !wait_irq_timing_select && enable_q && !start_det &&
		!stop_det) |=> wait_q && irq_stat_q[IRQ_XFER])
		else $error("eighth clock event missing");
	a_rx_sample: assert property (@(posedge core_clk) disable iff (!rstn)
		(active && scl_rise && !tx_bit_q && bit_cnt_q < BYTE_BITS && !wr_shift && !start_det &&
		!stop_det) |=> serial_shift_reg[0] == $past(sda_s))
		else $error("data line not sampled");
	a_master_fresh: assert property (@(posedge core_clk) disable iff (!rstn)
		ev_byte |=> !master_state_flag)
		else $error("master flag stale at event");
endmodule

// ===== slave_evt_pkg.sv
package slave_evt_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_SHIFT = 8'h08;
	localparam logic [7:0] OFF_OWN_ADDR = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	// control register fields
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_STOP_IRQ_EN = 1;
	localparam int unsigned CTRL_WAIT_TIMING = 2;
	localparam int unsigned CTRL_WAIT_REL = 3;
	localparam int unsigned CTRL_ACK_EN = 4;
	// status register fields
	localparam int unsigned ST_DIR = 0;
	localparam int unsigned ST_MASTER = 1;
	localparam int unsigned ST_ADDRESSED = 2;
	localparam int unsigned ST_EXT = 3;
	localparam int unsigned ST_ACK = 4;
	localparam int unsigned ST_STOP = 5;
	localparam int unsigned ST_BUSY = 6;
	localparam int unsigned ST_WAIT = 7;
	// interrupt status and mask fields
	localparam int unsigned IRQ_XFER = 0;
	localparam int unsigned IRQ_STOP = 1;
	localparam int unsigned IRQ_NACK = 2;
	localparam int unsigned IRQ_W = 3;
	// values after reset
	localparam logic [4:0] CTRL_RST = 5'h10;
	localparam logic [6:0] OWN_ADDR_RST = 7'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	// bit counts within one byte frame
	localparam logic [3:0] BYTE_BITS = 4'd8;
	localparam logic [3:0] ACK_CLK = 4'd9;
	// extension code prefixes and the wait release pattern
	localparam logic [3:0] EXT_PREFIX_LO = 4'h0;
	localparam logic [4:0] EXT_PREFIX_HI = 5'h1e;
	localparam logic [7:0] DATA_ALL_ONES = 8'hff;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_ADDR = 3'b010,
		PH_DATA = 3'b100
	} phase_t;
endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 2
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// two stages; the first is read by the second only, bus idles high
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			meta_q <= '1;
			q <= '1;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ===== i2c_master_model.sv
`timescale 1ns/1ps
// behavioural bus master on the far side; lines are open drain with pull-ups
module i2c_master_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_o,
	output logic sda_o,
	output logic [7:0] stall_err
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		stall_err = 8'h00;
	end
	// let clock rise, honouring a slave that stretches it; bounded so a hang is seen
	task automatic clk_hi;
		int n;
		scl_o = 1'b1;
		n = 0;
		while (scl !== 1'b1 && n < 4000) begin
			#5;
			n++;
		end
		if (n >= 4000) stall_err = stall_err + 8'h01;
	endtask
	// one bit: data set while clock low, sampled mid high
	task automatic bit_x(input logic b, output logic r);
		sda_o = b;
		#31.25;
		clk_hi();
		#31.25;
		r = sda;
		#31.25;
		scl_o = 1'b0;
		#31.25;
	endtask
	// byte msb first then ack slot; ack_in high is a nack when reading
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ack_in, ack);
	endtask
	task automatic start;
		sda_o = 1'b1;
		clk_hi();
		#62.5;
		sda_o = 1'b0;
		#62.5;
		scl_o = 1'b0;
		#31.25;
	endtask
	// exchange always ends with stop after the last byte
	task automatic stop;
		sda_o = 1'b0;
		#31.25;
		clk_hi();
		#62.5;
		sda_o = 1'b1;
		#62.5;
	endtask
endmodule

// ===== i2c_slave_event_tb.sv
`timescale 1ns/1ps
module i2c_slave_event_tb;
	import slave_evt_pkg::*;
	logic core_clk, rstn, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, scl_oe, sda_oe, scl_o, sda_o, irq, m_scl, m_sda;
	logic [7:0] stall_err, q;
	logic ack, r;
	int n_fail, total_checks;
	wire scl = m_scl & ~scl_oe;
	wire sda = m_sda & ~sda_oe;
	assign hready = hreadyout;
	i2c_slave_event dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_clock_pin_i(scl),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe(scl_oe), .serial_data_pin_i(sda),
		.serial_data_pin_o(sda_o), .serial_data_pin_oe(sda_oe), .serial_event_irq(irq));
	i2c_master_model m (.scl(scl), .sda(sda), .scl_o(m_scl), .sda_o(m_sda),
		.stall_err(stall_err));
	task automatic close_out;
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for the slave's ready; zero wait states expected but not assumed
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			n_fail++;
			close_out();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] v);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		v = hrdata;
		// step off the edge so callers see what the write just launched
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h00000000, v);
		chk(v & mk, e);
	endtask
	task automatic wait_irq;
		int n;
		for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge core_clk);
		if (n >= 200) begin
			n_fail++;
			close_out();
		end
	endtask
	// reset values and an unmapped word
	task automatic sc_regs;
		rdm(OFF_CTRL, 32'hffffffff, {27'h0, CTRL_RST});
		rdm(OFF_OWN_ADDR, 32'hffffffff, 32'h0);
		rdm(OFF_IRQ_MASK, 32'hffffffff, 32'h0);
		chk({hresp, scl_o, sda_o}, 3'h0);
		wr(8'h40, 32'h5a5a5a5a);
		rdm(8'h40, 32'hffffffff, 32'h0);
	endtask
	// master writes two bytes, the second refused by software
	task automatic sc_rx;
		wr(OFF_OWN_ADDR, 32'ha0);
		wr(OFF_IRQ_MASK, 32'h7);
		wr(OFF_CTRL, 32'h17);
		m.start();
		m.xfer(8'ha0, 1'b1, q, ack);
		chk(ack, 1'b0);
		wait_irq();
		chk(scl_oe, 1'b1);
		rdm(OFF_STATUS, 32'h0f, 32'h04);
		wr(OFF_IRQ_STAT, 32'h7);
		chk(irq, 1'b0);
		wr(OFF_CTRL, 32'h1f);
		chk(scl_oe, 1'b0);
		m.xfer(8'h3c, 1'b1, q, ack);
		chk(ack, 1'b0);
		wait_irq();
		rdm(OFF_SHIFT, 32'hff, 32'h3c);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_CTRL, 32'h07);
		wr(OFF_SHIFT, 32'hff);
		chk(scl_oe, 1'b0);
		m.xfer(8'hc3, 1'b1, q, ack);
		chk(ack, 1'b1);
		wait_irq();
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_CTRL, 32'h1f);
		m.stop();
		wait_irq();
		rdm(OFF_IRQ_STAT, 32'h2, 32'h2);
		wr(OFF_IRQ_STAT, 32'h7);
	endtask
	// master reads until it nacks
	task automatic sc_tx;
		m.start();
		m.xfer(8'ha1, 1'b1, q, ack);
		chk(ack, 1'b0);
		wait_irq();
		rdm(OFF_STATUS, 32'h3, 32'h1);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_SHIFT, 32'ha5);
		m.xfer(8'hff, 1'b0, q, ack);
		chk(q, 8'ha5);
		wait_irq();
		rdm(OFF_STATUS, 32'h2, 32'h0);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_SHIFT, 32'h5a);
		m.xfer(8'hff, 1'b1, q, ack);
		chk(q, 8'h5a);
		wait_irq();
		rdm(OFF_IRQ_STAT, 32'h4, 32'h4);
		chk(sda_oe, 1'b0);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_CTRL, 32'h1f);
		m.stop();
		wr(OFF_IRQ_STAT, 32'h7);
	endtask
	// foreign address, then extension code with event after clock eight
	task automatic sc_ext;
		wr(OFF_IRQ_MASK, 32'h0);
		wr(OFF_CTRL, 32'h11);
		m.start();
		m.xfer(8'h20, 1'b1, q, ack);
		chk(ack, 1'b1);
		m.stop();
		rdm(OFF_IRQ_STAT, 32'h7, 32'h0);
		m.start();
		m.xfer(8'h08, 1'b1, q, ack);
		chk(ack, 1'b0);
		repeat (20) @(posedge core_clk);
		chk(irq, 1'b0);
		rdm(OFF_STATUS, 32'h8, 32'h8);
		wr(OFF_IRQ_MASK, 32'h1);
		chk(irq, 1'b1);
		wr(OFF_IRQ_STAT, 32'h1);
		chk(irq, 1'b0);
		wr(OFF_CTRL, 32'h19);
		for (int i = 7; i >= 0; i--) m.bit_x(i[0], r);
		wait_irq();
		chk(scl_oe, 1'b1);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_CTRL, 32'h19);
		m.bit_x(1'b1, r);
		chk(r, 1'b0);
		m.stop();
	endtask
	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// hang guard, far beyond the longest sequence
	initial begin
		#400000;
		n_fail++;
		close_out();
	end
	initial begin
		n_fail = 0;
		total_checks = 0;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		sc_regs();
		sc_rx();
		sc_tx();
		sc_ext();
		chk(stall_err, 8'h00);
		close_out();
	end
endmodule
